// [hdl/ana_sel_pkg.sv]
// Constants, register map and reset values for the analog pin select block
//
// Behaviour
// - each analog-capable pin owns one analog_select_bit choosing analog or digital
// - select 1 gives analog mode, read disabled; 0 gives digital, read enabled
// - pin_level_read returns 0 for every pin configured as analog input
// - bank A implements select bits 10:9 and 7:6, reset to 1
// - bank B implements all sixteen select bits, reset to 1
// - bank C implements select bits 14:13 and 4, reset to 1
// - bank D implements bits 7:6 reset 1; bit 13 reserved reads 1
// - bank E implements select bits 9 and 4, reset to 1
// - bank G implements select bits 9:6, reset to 1
// - small package drops A bits 10,9,7, C bit 4, E bit 9
// - unimplemented select bits read 0 and ignore writes
// - direction 1 means input; all pins inputs after reset
package ana_sel_pkg;

    localparam int unsigned NUM_BANKS = 6;
    localparam int unsigned BANK_W    = 16;

    typedef logic [BANK_W-1:0] bank_t;

    // Bank index order: A, B, C, D, E, G
    localparam logic [2:0] BANK_A = 3'h0;
    localparam logic [2:0] BANK_B = 3'h1;
    localparam logic [2:0] BANK_C = 3'h2;
    localparam logic [2:0] BANK_D = 3'h3;
    localparam logic [2:0] BANK_E = 3'h4;
    localparam logic [2:0] BANK_G = 3'h5;

    // Writable select masks, full pin count
    localparam bank_t MASK_A = 16'h06C0;
    localparam bank_t MASK_B = 16'hFFFF;
    localparam bank_t MASK_C = 16'h6010;
    localparam bank_t MASK_D = 16'h00C0;
    localparam bank_t MASK_E = 16'h0210;
    localparam bank_t MASK_G = 16'h03C0;

    // Bits absent on the small package
    localparam bank_t DROP_A = 16'h0680;
    localparam bank_t DROP_C = 16'h0010;
    localparam bank_t DROP_E = 16'h0200;

    // Reserved bits that read as one
    localparam bank_t RSVD_ONE_D = 16'h2000;

    // Implemented select bits reset to one
    localparam bank_t SEL_RESET = 16'hFFFF;
    // All pins inputs after reset
    localparam bank_t DIR_RESET = 16'hFFFF;

    // AXI byte offsets
    localparam logic [7:0] OFF_SEL_A   = 8'h00;
    localparam logic [7:0] OFF_SEL_B   = 8'h04;
    localparam logic [7:0] OFF_SEL_C   = 8'h08;
    localparam logic [7:0] OFF_SEL_D   = 8'h0C;
    localparam logic [7:0] OFF_SEL_E   = 8'h10;
    localparam logic [7:0] OFF_SEL_G   = 8'h14;
    localparam logic [7:0] OFF_DIR_0   = 8'h20;
    localparam logic [7:0] OFF_LEVEL_0 = 8'h40;
    localparam int unsigned ADDR_W     = 8;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [hdl/pin_sync.sv]
// Two-flop synchroniser for one bank of pin inputs
`timescale 1ns/10ps
module pin_sync (
    input  wire logic                    clk,
    input  wire logic                    srst,
    input  wire ana_sel_pkg::bank_t      pin_async,
    output logic      [15:0]             pin_sync_out
);
    import ana_sel_pkg::*;

    typedef struct packed {
        bank_t meta;
        bank_t stable;
    } sync_state_t;

    sync_state_t s_q;
    sync_state_t s_d;

    always_comb begin
        s_d        = s_q;
        s_d.meta   = pin_async;
        s_d.stable = s_q.meta;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pin_sync_out = s_q.stable;
endmodule

// [hdl/analog_digital_pin_select.sv]
// AXI4-Lite register block selecting analog or digital function per port pin
`timescale 1ns/10ps
module analog_digital_pin_select (
    input  wire logic                                 clk,
    input  wire logic                                 srst,
    input  wire logic                                 small_package,
    input  wire logic [ana_sel_pkg::ADDR_W-1:0]       s_axi_awaddr,
    input  wire logic                                 s_axi_awvalid,
    output logic                                      s_axi_awready,
    input  wire logic [31:0]                          s_axi_wdata,
    input  wire logic [3:0]                           s_axi_wstrb,
    input  wire logic                                 s_axi_wvalid,
    output logic                                      s_axi_wready,
    output logic [1:0]                                s_axi_bresp,
    output logic                                      s_axi_bvalid,
    input  wire logic                                 s_axi_bready,
    input  wire logic [ana_sel_pkg::ADDR_W-1:0]       s_axi_araddr,
    input  wire logic                                 s_axi_arvalid,
    output logic                                      s_axi_arready,
    output logic [31:0]                               s_axi_rdata,
    output logic [1:0]                                s_axi_rresp,
    output logic                                      s_axi_rvalid,
    input  wire logic                                 s_axi_rready,
    input  wire logic [ana_sel_pkg::NUM_BANKS*16-1:0] pin_in,
    output logic [ana_sel_pkg::NUM_BANKS*16-1:0]      analog_select_bit,
    output logic [ana_sel_pkg::NUM_BANKS*16-1:0]      direction_bit,
    output logic [ana_sel_pkg::NUM_BANKS*16-1:0]      digital_in
);
    import ana_sel_pkg::*;

    typedef struct packed {
        bank_t [NUM_BANKS-1:0] sel;
        bank_t [NUM_BANKS-1:0] dir;
        bank_t [NUM_BANKS-1:0] dig;
        logic                  pkg_small;
        logic                  aw_held;
        logic [ADDR_W-1:0]     aw_addr;
        logic                  w_held;
        logic [31:0]           w_data;
        logic [3:0]            w_strb;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
        logic                  aw_rdy;
        logic                  w_rdy;
        logic                  ar_rdy;
    } state_t;

    state_t q;
    state_t d;
    bank_t  pin_s [NUM_BANKS];

    // Writable select bits of a bank, allowing for the package
    function automatic bank_t sel_mask(input logic [2:0] b, input logic few_pins);
        bank_t m;
        m = '0;
        case (b)
            BANK_A:  m = MASK_A & ~(few_pins ? DROP_A : bank_t'(0));
            BANK_B:  m = MASK_B;
            BANK_C:  m = MASK_C & ~(few_pins ? DROP_C : bank_t'(0));
            BANK_D:  m = MASK_D;
            BANK_E:  m = MASK_E & ~(few_pins ? DROP_E : bank_t'(0));
            BANK_G:  m = MASK_G;
            default: m = '0;
        endcase
        return m;
    endfunction

    // Decodes a word offset into kind (0 sel, 1 dir, 2 level) and bank
    function automatic logic [4:0] decode(input logic [ADDR_W-1:0] a);
        logic [4:0] r;
        logic [2:0] idx;
        r   = 5'h1F;
        idx = a[4:2];
        if (a[1:0] == 2'h0 && idx < 3'(NUM_BANKS)) begin
            if (a[7:5] == OFF_SEL_A[7:5]) begin
                r = {2'h0, idx};
            end else if (a[7:5] == OFF_DIR_0[7:5]) begin
                r = {2'h1, idx};
            end else if (a[7:5] == OFF_LEVEL_0[7:5]) begin
                r = {2'h2, idx};
            end
        end
        return r;
    endfunction

    genvar g;
    generate
        for (g = 0; g < NUM_BANKS; g++) begin : g_sync
            pin_sync u_sync (
                .clk          (clk),
                .srst         (srst),
                .pin_async    (pin_in[g*16 +: 16]),
                .pin_sync_out (pin_s[g])
            );
        end
    endgenerate

    always_comb begin
        logic [4:0] wd;
        logic [4:0] rd;
        bank_t      m;
        bank_t      wv;
        logic       wr_go;
        wd    = decode(q.aw_addr);
        rd    = decode(s_axi_araddr);
        m     = '0;
        wv    = '0;
        wr_go = 1'b0;
        d     = q;

        // Resample package strap every cycle out of reset; reset clears it to 0
        d.pkg_small = small_package;
        for (int i = 0; i < NUM_BANKS; i++) begin
            // Sync flop already hides metastability; gate after it
            d.dig[i] = pin_s[i] & ~q.sel[i];
            // Drop select bits that vanish with a package change
            d.sel[i] = q.sel[i] & sel_mask(3'(i), q.pkg_small);
        end

        // Write channel: address and data may come in either order
        if (s_axi_awvalid && !q.aw_held) begin
            d.aw_held = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !q.w_held) begin
            d.w_held = 1'b1;
            d.w_data = s_axi_wdata;
            d.w_strb = s_axi_wstrb;
        end
        if (q.aw_held && q.w_held && !q.bvalid) begin
            wr_go     = 1'b1;
            d.aw_held = 1'b0;
            d.w_held  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = RESP_OKAY;
        end
        if (wr_go) begin
            wv = {q.w_strb[1] ? q.w_data[15:8] : 8'h00, q.w_strb[0] ? q.w_data[7:0] : 8'h00};
            if (wd[4:3] == 2'h0) begin
                m = sel_mask(wd[2:0], q.pkg_small);
                // Unwritten byte lanes keep their old value
                m = m & {{8{q.w_strb[1]}}, {8{q.w_strb[0]}}};
                d.sel[wd[2:0]] = (q.sel[wd[2:0]] & ~m) | (wv & m);
            end else if (wd[4:3] == 2'h1) begin
                m = {{8{q.w_strb[1]}}, {8{q.w_strb[0]}}};
                d.dir[wd[2:0]] = (q.dir[wd[2:0]] & ~m) | (wv & m);
            end else begin
                // Level registers are read only
                d.bresp = RESP_SLVERR;
            end
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end

        // Read channel: one-cycle answer from a registered copy
        if (s_axi_arvalid && !q.rvalid) begin
            d.rvalid = 1'b1;
            d.rresp  = RESP_OKAY;
            d.rdata  = 32'h0000_0000;
            case (rd[4:3])
                2'h0: begin
                    d.rdata[15:0] = q.sel[rd[2:0]] & sel_mask(rd[2:0], q.pkg_small);
                    if (rd[2:0] == BANK_D) begin
                        d.rdata[15:0] = d.rdata[15:0] | RSVD_ONE_D;
                    end
                end
                2'h1: d.rdata[15:0] = q.dir[rd[2:0]];
                2'h2: d.rdata[15:0] = q.dig[rd[2:0]];
                default: d.rresp = RESP_SLVERR;
            endcase
        end
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end

        // Ready flags in flops so no gate sits after the register
        d.aw_rdy = !d.aw_held;
        d.w_rdy  = !d.w_held;
        d.ar_rdy = !d.rvalid;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            q         <= '0;
            for (int i = 0; i < NUM_BANKS; i++) begin
                q.sel[i] <= SEL_RESET & sel_mask(3'(i), 1'b0);
                q.dir[i] <= DIR_RESET;
            end
            q.aw_rdy  <= 1'b1;
            q.w_rdy   <= 1'b1;
            q.ar_rdy  <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign s_axi_awready = q.aw_rdy;
    assign s_axi_wready  = q.w_rdy;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_arready = q.ar_rdy;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rdata   = q.rdata;
    assign s_axi_rresp   = q.rresp;

    generate
        for (g = 0; g < NUM_BANKS; g++) begin : g_out
            assign analog_select_bit[g*16 +: 16] = q.sel[g];
            assign direction_bit[g*16 +: 16]     = q.dir[g];
            assign digital_in[g*16 +: 16]        = q.dig[g];
        end
    endgenerate
endmodule

// [dv/ana_sel_chk.sv]
// Property checks for the analog pin select block
`timescale 1ns/10ps
module ana_sel_chk (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        small_package,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [95:0] pin_in,
    input wire logic [95:0] analog_select_bit,
    input wire logic [95:0] direction_bit,
    input wire logic [95:0] digital_in
);
    import ana_sel_pkg::*;
    localparam logic [95:0] IMP = {MASK_G, MASK_E, MASK_D, MASK_C, MASK_B, MASK_A};
    localparam logic [95:0] RSV = {32'h0, RSVD_ONE_D, 48'h0};
    localparam logic [95:0] DRP = {16'h0, DROP_E, 16'h0, DROP_C, 16'h0, DROP_A};
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    a_sel_unimpl: assert property ((analog_select_bit & ~(IMP | RSV)) == 0)
        else $error("select bit outside mask");
    a_sel_reset: assert property (
        $past(srst) |-> (analog_select_bit & ~RSV) == IMP) else $error("select reset value");
    a_dir_reset: assert property ($past(srst) |-> direction_bit == '1)
        else $error("direction reset value");
    a_small_drop: assert property (small_package [*4] |-> (analog_select_bit & DRP) == 0)
        else $error("absent select bit set");
    a_gate_sel: assert property (
        (digital_in & analog_select_bit & $past(analog_select_bit)) == 0) else $error("gate open");
    // Reserved bank D bit left out, its select level is not defined
    a_sync_lat: assert property (
        ((analog_select_bit & ~RSV) == 0) [*4] |-> (digital_in & ~RSV) == ($past(pin_in, 3) & ~RSV))
        else $error("digital input latency");
    a_sel_d_read: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_SEL_D |=> s_axi_rdata ==
        {16'h0, 16'($past(analog_select_bit) >> 48) & MASK_D | RSVD_ONE_D}) else $error("bank d read");
    a_level_read: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_LEVEL_0 |=> s_axi_rdata ==
        {16'h0, 16'($past(digital_in))}) else $error("level read");
endmodule
bind analog_digital_pin_select ana_sel_chk chk (
    .clk, .srst, .small_package, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .pin_in, .analog_select_bit, .direction_bit, .digital_in
);

// [dv/analog_digital_pin_select_tb_top.sv]
// Bench for the analog pin select block
`timescale 1ns/10ps
module analog_digital_pin_select_tb_top;
    import ana_sel_pkg::*;
    typedef struct packed {logic [7:0] a; logic [31:0] d; bank_t e;} row_t;
    logic        clk = 0, srst = 1, pkg = 0;
    logic        awv = 0, wv = 0, br = 0, arv = 0, rr = 0, awr, wrd, bv, arr, rv;
    logic [7:0]  awa = 0, ara = 0;
    logic [31:0] wd = 0, rdat;
    logic [3:0]  ws = 0;
    logic [1:0]  bre, rre;
    logic [95:0] pin = 0, din, selb, dirb;
    int          fails = 0, comparisons = 0, n, i;
    // Bank D bit 13 kept low so its undefined select cannot hide it
    localparam logic [95:0] PAT = 96'hA5A5_5A5A_0FF0_0F0F_3C3C_C3C3;
    bank_t m [6] = '{MASK_A, MASK_B, MASK_C, MASK_D | RSVD_ONE_D, MASK_E, MASK_G};
    row_t rows [8] = '{'{8'h04, 32'h1234_5678, 16'h5678}, '{8'h04, 32'h0, 16'h0},
        '{8'h00, 32'h0, 16'h0}, '{8'h08, 32'h0, 16'h0}, '{8'h0C, 32'h0, 16'h2000},
        '{8'h10, 32'h0, 16'h0}, '{8'h14, 32'h0, 16'h0}, '{8'h20, 32'h0, 16'h0}};
    analog_digital_pin_select uut (
        .clk(clk), .srst(srst), .small_package(pkg),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd),
        .s_axi_bresp(bre), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rre), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .pin_in(pin), .analog_select_bit(selb), .direction_bit(dirb), .digital_in(din)
    );
    always #5 clk = ~clk;
    task automatic ck(string nm, logic [95:0] g, logic [95:0] e);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s exp %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic tmo();
        if (n == 50) begin
            fails++;
            end_of_test();
        end
    endtask
    task automatic wt(logic [7:0] a, logic [31:0] d, logic [3:0] s, logic [1:0] er);
        @(posedge clk);
        awa <= a;
        wd <= d;
        ws <= s;
        awv <= 1;
        wv <= 1;
        br <= 1;
        for (n = 0; n < 50 && !bv; n++) begin
            @(posedge clk);
            if (awr) awv <= 0;
            if (wrd) wv <= 0;
        end
        br <= 0;
        tmo();
        ck("bresp", bre, er);
    endtask
    task automatic rt(logic [7:0] a, logic [31:0] e, logic [1:0] er, bit cd);
        @(posedge clk);
        ara <= a;
        arv <= 1;
        rr <= 1;
        for (n = 0; n < 50 && !rv; n++) begin
            @(posedge clk);
            if (arr) arv <= 0;
        end
        rr <= 0;
        tmo();
        if (cd) ck("rdata", rdat, e);
        ck("rresp", rre, er);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        srst <= 0;
        for (i = 0; i < 6; i++) begin
            rt(8'(4 * i), m[i], 0, 1);
            rt(8'(32 + 4 * i), 32'hFFFF, 0, 1);
        end
        ck("sel out", selb, {MASK_G, MASK_E, MASK_D, MASK_C, MASK_B, MASK_A});
        ck("dir out", dirb, {6{16'hFFFF}});
        $display("reset values done");
        for (i = 0; i < 8; i++) begin
            wt(rows[i].a, rows[i].d, 4'hF, 0);
            rt(rows[i].a, rows[i].e, 0, 1);
        end
        $display("register rows done");
        pin <= PAT;
        // Sync depth plus margin before trusting reads
        repeat (5) @(posedge clk);
        ck("din", din, PAT);
        for (i = 0; i < 6; i++) rt(8'(64 + 4 * i), PAT[16*i+:16], 0, 1);
        wt(8'h04, 32'h0000_FFFF, 4'h2, 0);
        rt(8'h04, 32'hFF00, 0, 1);
        rt(8'h44, PAT[31:16] & 16'h00FF, 0, 1);
        wt(8'h40, 32'h0, 4'hF, RESP_SLVERR);
        rt(8'h40, PAT[15:0], 0, 1);
        wt(8'h80, 32'h0, 4'hF, RESP_SLVERR);
        rt(8'h80, 0, RESP_SLVERR, 0);
        // Analog use: select and direction both set on bank B
        wt(8'h04, 32'h0000_FFFF, 4'h3, 0);
        rt(8'h24, 32'hFFFF, 0, 1);
        ck("dir out b", dirb[31:16], 16'hFFFF);
        repeat (3) @(posedge clk);
        ck("din b", din[31:16], 16'h0000);
        ck("sel out b", selb[31:16], 16'hFFFF);
        rt(8'h44, 32'h0, 0, 1);
        $display("gating and refusals done");
        pkg <= 1;
        srst <= 1;
        repeat (2) @(posedge clk);
        srst <= 0;
        repeat (4) @(posedge clk);
        rt(8'h00, 32'h0040, 0, 1);
        rt(8'h08, 32'h6000, 0, 1);
        rt(8'h10, 32'h0010, 0, 1);
        $display("small package done");
        end_of_test();
    end
endmodule
